// ==== design/nvw_host.sv ====
// Host-side write controller driving a byte-wide battery-backed SRAM.
// Assumes the memory's strobes and data pins sit on this block's ports and
// that a supply monitor reports when the supply is below threshold.
`timescale 1ns/100ps
`default_nettype none
module nvw_host
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic wr_req, // Request a write, level
  input wire logic [nvw_pkg::NVW_ADDR_W-1:0] wr_addr, // Byte address
  input wire logic [nvw_pkg::NVW_DATA_W-1:0] wr_data, // Byte to write
  input wire logic power_fail_threshold, // Supply below deselect level
  input wire logic gate_low_req, // Read path asks gate low when idle
  output logic wr_ack, // Request taken, one-cycle pulse
  output logic wr_done, // Write finished, one-cycle pulse
  output logic wr_blocked, // Refused for low supply, high each cycle the request is held
  output logic busy, // Controller not idle
  output logic chip_en_n, // Chip enable, active low
  output logic write_n, // Write strobe, active low
  output logic gate_n, // Output gate, active low
  output logic [nvw_pkg::NVW_ADDR_W-1:0] address_lines, // Address pins
  output logic [nvw_pkg::NVW_DATA_W-1:0] data_lines_o, // Data drive
  output logic data_lines_oe_n, // Data drive enable, low drives
  input wire logic [nvw_pkg::NVW_DATA_W-1:0] data_lines_i // Data pins in
);
  import nvw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state

  typedef struct packed {
    nvw_state_e state;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic doe_n;
    logic [NVW_ADDR_W-1:0] addr;
    logic [NVW_DATA_W-1:0] data;
    logic ack;
    logic done;
    logic blk;
    logic busy;
  } nvw_host_s;

  nvw_host_s st_r;
  nvw_host_s st_nxt;
  logic tmr_load;
  nvw_cnt_t tmr_val;
  logic tmr_done;

  // Enable and strobe move as one: neither edge can lead the other,
  // so the memory never turns its outputs on during a write
  function automatic nvw_host_s nvw_strobes(input nvw_host_s s,
    input logic lvl);
    nvw_host_s r;
    r = s;
    r.ce_n = lvl;
    r.we_n = lvl;
    return r;
  endfunction : nvw_strobes

  ////////////////////////////////////////////////////////////////////////
  // Phase timer: one counter, loaded at take and as each phase before recovery ends

  nvw_timer u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write sequencer

  always_comb
  begin
    st_nxt = st_r;
    tmr_load = 1'b0;
    tmr_val = NVW_CNT_ONE;
    // Pulses are low unless a phase raises them
    st_nxt.ack = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.blk = 1'b0;
    case (st_r.state)
      NVW_IDLE:
      begin
        // Strobes high; gate follows the read path until a write is taken
        st_nxt = nvw_strobes(st_nxt, 1'b1);
        st_nxt.doe_n = 1'b1;
        st_nxt.oe_n = ~gate_low_req;
        if (wr_req && power_fail_threshold)
        begin
          // Supply low: memory ignores all access, so never start one
          st_nxt.blk = 1'b1;
        end
        else if (wr_req)
        begin
          st_nxt.ack = 1'b1;
          st_nxt.addr = wr_addr;
          st_nxt.data = wr_data;
          st_nxt.oe_n = 1'b1;
          st_nxt.busy = 1'b1;
          tmr_load = 1'b1;
          if (st_r.oe_n)
          begin
            tmr_val = NVW_CYC_ASU;
            st_nxt.state = NVW_ASU;
          end
          else
          begin
            // Gate was low: let the memory release the bus first
            tmr_val = NVW_CYC_ODW;
            st_nxt.state = NVW_ODW;
          end
        end
      end
      NVW_ODW, NVW_ASU:
      begin
        // Address and data settled at take; gate already high here
        if (tmr_done)
        begin
          // Strobe falls with enable so the memory never drives
          st_nxt = nvw_strobes(st_nxt, 1'b0);
          st_nxt.doe_n = 1'b0;
          tmr_load = 1'b1;
          tmr_val = NVW_CYC_WP;
          st_nxt.state = NVW_PULSE;
        end
      end
      NVW_PULSE:
      begin
        if (tmr_done)
        begin
          // Both rise together; this edge latches the byte
          st_nxt = nvw_strobes(st_nxt, 1'b1);
          tmr_load = 1'b1;
          tmr_val = NVW_CYC_DH;
          st_nxt.state = NVW_HOLD;
        end
      end
      NVW_HOLD:
      begin
        if (tmr_done)
        begin
          // Drive held one cycle past the rising edge for data hold
          st_nxt.doe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = NVW_CYC_WR;
          st_nxt.state = NVW_RECOV;
        end
      end
      NVW_RECOV:
      begin
        // Strobe stays high the recovery time before the next take
        if (tmr_done)
        begin
          st_nxt.done = 1'b1;
          st_nxt.busy = 1'b0;
          st_nxt.state = NVW_IDLE;
        end
      end
      default:
      begin
        // Unknown state: park every pin at its inactive level
        st_nxt = nvw_strobes(st_nxt, 1'b1);
        st_nxt.doe_n = 1'b1;
        st_nxt.oe_n = 1'b1;
        st_nxt.state = NVW_IDLE;
        st_nxt.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      // Pins inactive, handshake quiet
      st_r <= '{
        state: NVW_IDLE,
        ce_n: 1'b1,
        we_n: 1'b1,
        oe_n: 1'b1,
        doe_n: 1'b1,
        addr: '0,
        data: '0,
        ack: 1'b0,
        done: 1'b0,
        blk: 1'b0,
        busy: 1'b0
      };
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins: address and data only change in idle, so stable per cycle

  // Memory side
  assign chip_en_n = st_r.ce_n;
  assign write_n = st_r.we_n;
  assign gate_n = st_r.oe_n;
  assign address_lines = st_r.addr;
  assign data_lines_o = st_r.data;
  assign data_lines_oe_n = st_r.doe_n;

  // Request side
  assign wr_ack = st_r.ack;
  assign wr_done = st_r.done;
  assign wr_blocked = st_r.blk;
  assign busy = st_r.busy;

endmodule : nvw_host
`default_nettype wire

// ==== common/nvw_pkg.sv ====
// Constants and types for the host-side write controller of a byte-wide
// battery-backed SRAM. Assumes a 100 MHz sys_clk and pins sampled
// synchronously; the memory itself has no clock.
package nvw_pkg;

  localparam int unsigned NVW_ADDR_W = 19;
  localparam int unsigned NVW_DATA_W = 8;
  localparam int unsigned NVW_CLK_NS = 10;

  // Timing figures in ns, as printed
  localparam int unsigned NVW_T_SETUP_ADDR_NS = 0;
  localparam int unsigned NVW_T_WP_NS = 50;
  localparam int unsigned NVW_T_DS_NS = 30;
  localparam int unsigned NVW_T_DH_NS = 10;
  localparam int unsigned NVW_T_WR_NS = 15;
  localparam int unsigned NVW_T_ODW_NS = 25;

  // Least times round up; none below one cycle
  function automatic int unsigned nvw_cyc_min(input int unsigned ns);
    int unsigned c;
    c = (ns + NVW_CLK_NS - 1) / NVW_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : nvw_cyc_min

  localparam int unsigned NVW_CNT_W = 4;
  typedef logic [NVW_CNT_W-1:0] nvw_cnt_t;

  localparam nvw_cnt_t NVW_CYC_ASU = nvw_cnt_t'(nvw_cyc_min(NVW_T_SETUP_ADDR_NS));
  localparam nvw_cnt_t NVW_CYC_ODW = nvw_cnt_t'(nvw_cyc_min(NVW_T_ODW_NS));
  localparam nvw_cnt_t NVW_CYC_WP =
    nvw_cnt_t'(nvw_cyc_min((NVW_T_WP_NS > NVW_T_DS_NS) ? NVW_T_WP_NS
                                                        : NVW_T_DS_NS));
  localparam nvw_cnt_t NVW_CYC_DH = nvw_cnt_t'(nvw_cyc_min(NVW_T_DH_NS));
  localparam nvw_cnt_t NVW_CYC_WR = nvw_cnt_t'(nvw_cyc_min(NVW_T_WR_NS));
  localparam nvw_cnt_t NVW_CNT_ONE = 4'h1;
  localparam nvw_cnt_t NVW_CNT_ZERO = 4'h0;

  typedef enum logic [2:0] {
    NVW_IDLE = 3'h0,
    NVW_ASU = 3'h1,
    NVW_ODW = 3'h2,
    NVW_PULSE = 3'h3,
    NVW_HOLD = 3'h4,
    NVW_RECOV = 3'h5
  } nvw_state_e;

endpackage : nvw_pkg

// ==== design/nvw_timer.sv ====
// Down counter for the write controller's phase lengths.
// Assumes load and count are synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module nvw_timer
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic load, // Load a new count
  input wire nvw_pkg::nvw_cnt_t load_val, // Count to load
  output logic done // Count has reached one or less
);
  import nvw_pkg::*;

  typedef struct packed {
    nvw_cnt_t cnt;
  } nvw_tmr_s;

  nvw_tmr_s st_r;
  nvw_tmr_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (load)
    begin
      st_nxt.cnt = load_val;
    end
    else if (st_r.cnt > NVW_CNT_ZERO)
    begin
      st_nxt.cnt = st_r.cnt - NVW_CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign done = (st_r.cnt <= NVW_CNT_ONE);

endmodule : nvw_timer
`default_nettype wire

// ==== tb/nvw_props.sv ====
// Checker for nvw_host pins
// Sees top ports only; bound from the bench
`timescale 1ns/100ps
`default_nettype none
module nvw_props
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic wr_req, // Request
  input wire logic power_fail_threshold, // Low supply
  input wire logic wr_ack, // Taken
  input wire logic wr_done, // Finished
  input wire logic wr_blocked, // Refused
  input wire logic busy, // Busy
  input wire logic chip_en_n, // Enable
  input wire logic write_n, // Strobe
  input wire logic gate_n, // Gate
  input wire logic [nvw_pkg::NVW_ADDR_W-1:0] address_lines, // Address
  input wire logic data_lines_oe_n // Drive
);
  import nvw_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_pulse; !write_n[*5] ##1 write_n; endsequence
  sequence s_hold; !data_lines_oe_n ##1 data_lines_oe_n; endsequence
  property p_tog; chip_en_n == write_n; endproperty
  a_tog: assert property (p_tog) else $error("strobes split");
  property p_gate; !write_n |-> gate_n; endproperty
  a_gate: assert property (p_gate) else $error("gate low");
  property p_addr; $past(!write_n) && !write_n |-> $stable(address_lines);
  endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
  property p_pw; $fell(write_n) |-> s_pulse; endproperty
  a_pw: assert property (p_pw) else $error("pulse width");
  property p_dh; $rose(write_n) |-> s_hold; endproperty
  a_dh: assert property (p_dh) else $error("data hold");
  property p_rec; $rose(write_n) |-> write_n[*3]; endproperty
  a_rec: assert property (p_rec) else $error("recovery");
  property p_blk; wr_req && power_fail_threshold && !busy |=> wr_blocked;
  endproperty
  a_blk: assert property (p_blk) else $error("not refused");
  property p_ack; wr_req && !power_fail_threshold && !busy |=> wr_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("not taken");
  property p_done; $fell(write_n) |-> ##8 wr_done; endproperty
  a_done: assert property (p_done) else $error("done late");
endmodule : nvw_props
`default_nettype wire

// ==== tb/nvw_mem.sv ====
// Memory stand-in: stores at end of write, drives on reads
// Assumes host pins registered; no timing checks
`timescale 1ns/100ps
`default_nettype none
module nvw_mem
(
  input wire logic chip_en_n, // Enable
  input wire logic write_n, // Strobe
  input wire logic gate_n, // Gate
  input wire logic power_fail_threshold, // Low supply
  input wire logic [nvw_pkg::NVW_ADDR_W-1:0] address_lines, // Address
  input wire logic [nvw_pkg::NVW_DATA_W-1:0] data_lines_o, // Host drive
  input wire logic data_lines_oe_n, // Host enable
  output logic [nvw_pkg::NVW_DATA_W-1:0] data_lines_i, // Bus
  output logic clash // Both drove
);
  import nvw_pkg::*;
  logic [7:0] mem [0:524287];
  logic wr_on;
  logic rd_on;
  assign wr_on = !chip_en_n && !write_n;
  assign rd_on = !chip_en_n && !gate_n && write_n
    && !power_fail_threshold;
  // Earlier rising edge ends the write
  always @(negedge wr_on)
    if (!power_fail_threshold)
      mem[address_lines] = data_lines_oe_n ? 8'hXX : data_lines_o;
  // No pull: released lines show the inverse of the last drive
  assign data_lines_i = rd_on ? mem[address_lines] : ~data_lines_o;
  // Sticky; one process owns it
  initial
  begin
    clash = 1'b0;
    forever
    begin
      @(rd_on or data_lines_oe_n);
      if (rd_on && !data_lines_oe_n)
        clash = 1'b1;
    end
  end
endmodule : nvw_mem
`default_nettype wire

// ==== tb/nvw_host_bench.sv ====
// Bench for nvw_host: write walks, gate paths, supply lockout
// Assumes nvw_mem stands in for the memory
`timescale 1ns/100ps
`default_nettype none
module nvw_host_bench;
  import nvw_pkg::*;
  logic sys_clk, rst, wr_req, pft, glr, ack, done, blk, busy;
  logic ce_n, we_n, g_n, oe_n, clash;
  logic [NVW_ADDR_W-1:0] wr_addr, adr;
  logic [NVW_DATA_W-1:0] wr_data, dout, din;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  nvw_host dut_u (.sys_clk(sys_clk), .rst(rst), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .power_fail_threshold(pft),
    .gate_low_req(glr), .wr_ack(ack), .wr_done(done), .wr_blocked(blk),
    .busy(busy), .chip_en_n(ce_n), .write_n(we_n), .gate_n(g_n),
    .address_lines(adr), .data_lines_o(dout), .data_lines_oe_n(oe_n),
    .data_lines_i(din));
  nvw_mem mem_u (.chip_en_n(ce_n), .write_n(we_n), .gate_n(g_n),
    .power_fail_threshold(pft), .address_lines(adr), .data_lines_o(dout),
    .data_lines_oe_n(oe_n), .data_lines_i(din), .clash(clash));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic t_write(input logic [18:0] a, input logic [7:0] d,
    input logic g);
    int n;
    n = 0;
    glr = g;
    step;
    wr_addr = a;
    wr_data = d;
    wr_req = 1'b1;
    step;
    while (ack !== 1'b1 && n < 5)
    begin
      step;
      n++;
    end
    wr_req = 1'b0;
    check(ack, 1'b1);
    check(adr, a);
    check(dout, d);
    check(busy, 1'b1);
    check(g_n, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      step;
      n++;
    end
    check(n, g ? 11 : 9);
    check({done, busy}, 2'h2);
    check(mem_u.mem[a], d);
    check(clash, 1'b0);
  endtask : t_write
  task automatic t_block;
    pft = 1'b1;
    wr_data = 8'h5A;
    wr_req = 1'b1;
    step;
    check(blk, 1'b1);
    wr_req = 1'b0;
    repeat (12) step;
    check({ack, we_n}, 2'h1);
    check(mem_u.mem[wr_addr], 8'hC3);
    pft = 1'b0;
  endtask : t_block
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Cuts a hang short
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      end_sim;
    end
  end
  initial
  begin
    rst = 1'b1;
    wr_req = 1'b0;
    pft = 1'b0;
    glr = 1'b0;
    wr_addr = '0;
    wr_data = '0;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    check({ce_n, we_n, g_n, oe_n}, 4'hF);
    t_write(19'h00000, 8'hA5, 1'b0);
    t_write(19'h7FFFF, 8'h3C, 1'b1);
    t_write(19'h7FFFF, 8'hC3, 1'b0);
    t_block;
    end_sim;
  end
endmodule : nvw_host_bench
bind nvw_host nvw_props chk_u (.sys_clk, .rst, .wr_req,
  .power_fail_threshold, .wr_ack, .wr_done, .wr_blocked, .busy,
  .chip_en_n, .write_n, .gate_n, .address_lines, .data_lines_oe_n);
`default_nettype wire
